// *** core/strobe_delay_dll_control.sv ***
// Delay loop, offset unit, update enable and two strobe lanes.
// Assumes ref_clk_in and both strobe pins are asynchronous to clk_in;
// all configuration inputs come from logic on clk_in.
`timescale 1ns/1ns
`include "sdc_consts.svh"

module strobe_delay_dll_control (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       ref_clk_in,
    input  wire logic       dll_reset_in,
    input  wire logic [1:0] freq_mode_in,
    input  wire logic       zero_shift_in,
    input  wire logic [1:0] offset_mode_in,
    input  wire logic [6:0] static_offset_in,
    input  wire logic [5:0] dyn_offset_in,
    input  wire logic       addnsub_in,
    input  wire logic       user_sel_in,
    input  wire logic [5:0] user_delay_in,
    input  wire logic       use_offset_in,
    input  wire logic [1:0] extra_elems_in,
    input  wire logic       dqs_pin_in,
    input  wire logic       dqsn_pin_in,
    input  wire logic       dqs_postamble_in,
    input  wire logic       dqsn_postamble_in,
    output logic [5:0]      delay_setting_out,
    output logic            upndn_out,
    output logic            upd_en_out,
    output logic            locked_out,
    output logic            dqs_shifted_out,
    output logic            dqsn_shifted_out
);

    sdc_pkg::dll_regs_t r_ff;
    sdc_pkg::dll_regs_t nxt_r;

    logic              ref_rise;
    logic [4:0]        elems;
    logic [11:0]       chain_delay;
    logic [11:0]       target_delay;
    logic              want_up;
    logic [5:0]        lane_setting;
    logic signed [7:0] offset;
    logic signed [8:0] sum_wide;
    logic [6:0]        lane_sum;

    // ========================================================
    // Reference edge detection
    // ========================================================
    // Only the second synchroniser stage and its delayed copy are read.
    assign ref_rise = r_ff.ref_s2 & ~r_ff.ref_prev;

    // ========================================================
    // Loop chain model and phase comparator
    // ========================================================
    // The chain delay in taps is the element count of the mode times the
    // setting; alignment is reached when it equals one reference period.
    always_comb begin
        case (freq_mode_in)
            2'h0:    elems = `SDC_ELEMS_M0;
            2'h1:    elems = `SDC_ELEMS_M1;
            2'h2:    elems = `SDC_ELEMS_M2;
            default: elems = `SDC_ELEMS_M3;
        endcase
        chain_delay  = 12'(elems) * 12'(r_ff.setting);
        target_delay = 12'(r_ff.period) * 12'(`SDC_TAPS_PER_CLK);
        want_up      = chain_delay < target_delay;
    end

    // ========================================================
    // Lane setting source
    // ========================================================
    // A lane takes the loop setting or the user setting; modes 1 to 3
    // keep only the low five bits of the user setting.
    always_comb begin
        if (user_sel_in) begin
            lane_setting = user_delay_in
                         & sdc_pkg::cnt_max(freq_mode_in);
        end else begin
            lane_setting = r_ff.setting;
        end
    end

    // ========================================================
    // Offset unit
    // ========================================================
    // Builds the signed offset, limits it to the mode's range, then adds
    // it to the lane setting and clamps the result.
    always_comb begin
        case (sdc_pkg::offset_mode_t'(offset_mode_in))
            sdc_pkg::OFS_STATIC: begin
                offset = {static_offset_in[6], static_offset_in};
            end
            sdc_pkg::OFS_DYN_ADD: begin
                offset = {2'h0, dyn_offset_in};
            end
            sdc_pkg::OFS_DYN_SUB: begin
                offset = -{2'h0, dyn_offset_in};
            end
            default: begin
                offset = addnsub_in ? {2'h0, dyn_offset_in}
                                    : -{2'h0, dyn_offset_in};
            end
        endcase
        // Mode 0 spans -64..63 by width; other modes are limited here.
        if (offset_mode_in == 2'h0 && freq_mode_in == 2'h0) begin
            offset = offset;
        end else if (offset_mode_in == 2'h0) begin
            if (offset > `SDC_OFS_HI_M123) begin
                offset = `SDC_OFS_HI_M123;
            end else if (offset < `SDC_OFS_LO_M123) begin
                offset = `SDC_OFS_LO_M123;
            end
        end else if (freq_mode_in != 2'h0) begin
            offset = {offset[7], offset[7], offset[7],
                      offset[4:0]};
            if (offset > `SDC_OFS_HI_M123) begin
                offset = `SDC_OFS_HI_M123;
            end else if (offset < `SDC_OFS_LO_M123) begin
                offset = `SDC_OFS_LO_M123;
            end
        end
        if (offset_mode_in != 2'h0 && freq_mode_in == 2'h0
            && offset == -8'sh40) begin
            offset = -8'sh3F;
        end
        sum_wide = $signed({3'h0, lane_setting})
                 + $signed({offset[7], offset});
        if (sum_wide < 9'sh000) begin
            lane_sum = 7'h00;
        end else if (sum_wide > $signed({2'h0,
                     sdc_pkg::max_setting(freq_mode_in)})) begin
            lane_sum = sdc_pkg::max_setting(freq_mode_in);
        end else begin
            lane_sum = sum_wide[6:0];
        end
    end

    // ========================================================
    // Loop state machine, counter, lock and update enable
    // ========================================================
    // After a loop reset the period is measured over one reference
    // cycle, then the counter tracks one step per reference edge.
    always_comb begin
        nxt_r = r_ff;
        nxt_r.ref_s1   = ref_clk_in;
        nxt_r.ref_s2   = r_ff.ref_s1;
        nxt_r.ref_prev = r_ff.ref_s2;
        nxt_r.upd_en   = 1'b0;
        if (ref_rise) begin
            nxt_r.per_cnt = 8'h01;
        end else if (r_ff.per_cnt != 8'hFF) begin
            nxt_r.per_cnt = r_ff.per_cnt + 8'h01;
        end
        // Update enable pulses once every few reference cycles so new
        // settings have time to reach every lane between changes.
        if (ref_rise) begin
            if (r_ff.upd_cnt == `SDC_UPD_CYCLES) begin
                nxt_r.upd_cnt = 3'h0;
                nxt_r.upd_en  = 1'b1;
            end else begin
                nxt_r.upd_cnt = r_ff.upd_cnt + 3'h1;
            end
        end
        case (r_ff.state)
            sdc_pkg::ST_RESET: begin
                nxt_r.setting  = `SDC_SETTING_RST;
                nxt_r.lock_cnt = 9'h000;
                nxt_r.locked   = 1'b0;
                if (ref_rise) begin
                    nxt_r.state = sdc_pkg::ST_MEASURE;
                end
            end
            sdc_pkg::ST_MEASURE: begin
                if (ref_rise) begin
                    nxt_r.period   = r_ff.per_cnt;
                    nxt_r.lock_cnt = r_ff.lock_cnt + 9'h001;
                    nxt_r.state    = sdc_pkg::ST_TRACK;
                end
            end
            default: begin
                if (ref_rise) begin
                    nxt_r.period = r_ff.per_cnt;
                    if (r_ff.lock_cnt != `SDC_LOCK_CYCLES) begin
                        nxt_r.lock_cnt = r_ff.lock_cnt + 9'h001;
                    end
                    nxt_r.upndn = want_up;
                    if (zero_shift_in) begin
                        nxt_r.setting = r_ff.setting;
                    end else if (want_up) begin
                        if (r_ff.setting
                            < sdc_pkg::cnt_max(freq_mode_in)) begin
                            nxt_r.setting = r_ff.setting + 6'h01;
                        end else begin
                            nxt_r.setting =
                                sdc_pkg::cnt_max(freq_mode_in);
                        end
                    end else if (r_ff.setting != 6'h00) begin
                        nxt_r.setting = r_ff.setting - 6'h01;
                    end
                end
                nxt_r.locked = (r_ff.lock_cnt == `SDC_LOCK_CYCLES)
                             && (r_ff.period != `SDC_PERIOD_RST);
            end
        endcase
        // A loop reset clears the setting and the lock at once, so user
        // logic never sees a stale lock while the loop starts over.
        if (dll_reset_in) begin
            nxt_r.state = sdc_pkg::ST_RESET;
            nxt_r.setting  = `SDC_SETTING_RST;
            nxt_r.lock_cnt = 9'h000;
            nxt_r.locked   = 1'b0;
        end
    end

    // Register the loop state.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            r_ff <= '{state: sdc_pkg::ST_RESET,
                      ref_s1: 1'b0, ref_s2: 1'b0, ref_prev: 1'b0,
                      per_cnt: 8'h00, period: `SDC_PERIOD_RST,
                      setting: `SDC_SETTING_RST, upndn: 1'b0,
                      lock_cnt: 9'h000, locked: 1'b0,
                      upd_cnt: 3'h0, upd_en: 1'b0};
        end else begin
            r_ff <= nxt_r;
        end
    end

    // ========================================================
    // Strobe lanes
    // ========================================================
    // One lane per pin; both lanes take the same setting, offset sum, update
    // enable and zero shift bypass.
    sdc_strobe_lane u_dqs_lane (
        .clk_in         (clk_in),
        .rst_in         (rst_in),
        .pin_in         (dqs_pin_in),
        .postamble_in   (dqs_postamble_in),
        .upd_en_in      (r_ff.upd_en),
        .setting_in     (lane_setting),
        .sum_in         (lane_sum),
        .use_offset_in  (use_offset_in),
        .extra_elems_in (extra_elems_in),
        .bypass_in      (zero_shift_in),
        .strobe_out     (dqs_shifted_out)
    );

    sdc_strobe_lane u_dqsn_lane (
        .clk_in         (clk_in),
        .rst_in         (rst_in),
        .pin_in         (dqsn_pin_in),
        .postamble_in   (dqsn_postamble_in),
        .upd_en_in      (r_ff.upd_en),
        .setting_in     (lane_setting),
        .sum_in         (lane_sum),
        .use_offset_in  (use_offset_in),
        .extra_elems_in (extra_elems_in),
        .bypass_in      (zero_shift_in),
        .strobe_out     (dqsn_shifted_out)
    );

    // Loop outputs for user logic.
    assign delay_setting_out = r_ff.setting;
    assign upndn_out         = r_ff.upndn;
    assign upd_en_out        = r_ff.upd_en;
    assign locked_out        = r_ff.locked;

endmodule : strobe_delay_dll_control

// *** include/sdc_consts.svh ***
// Constants of the strobe delay loop and its strobe lanes.
// Assumes inclusion by the package and the design modules.
`ifndef SDC_CONSTS_SVH
`define SDC_CONSTS_SVH

// Delay elements in the loop chain per frequency mode.
`define SDC_ELEMS_M0      5'h0C
`define SDC_ELEMS_M1      5'h10
`define SDC_ELEMS_M2      5'h0C
`define SDC_ELEMS_M3      5'h0A
// Largest combined setting per mode.
`define SDC_MAX_M0        7'h40
`define SDC_MAX_M123      7'h20
// Largest counter value per mode.
`define SDC_CNT_M0        6'h3F
`define SDC_CNT_M123      6'h1F
// Signed offset limits for modes 1 to 3.
`define SDC_OFS_HI_M123   8'sh1F
`define SDC_OFS_LO_M123   -8'sh20
// Reference cycles before captured data is trusted.
`define SDC_LOCK_CYCLES   9'h100
// Chain taps that equal one sampling clock cycle.
`define SDC_TAPS_PER_CLK  5'h10
// Last update counter value; setting updates come every eight reference cycles.
`define SDC_UPD_CYCLES    3'h7
// Reset values.
`define SDC_SETTING_RST   6'h00
`define SDC_PERIOD_RST    8'h00
`define SDC_HIST_RST      32'h0000_0000

`endif

// *** include/sdc_pkg.sv ***
// Types and shared arithmetic of the strobe delay loop.
// Assumes the constants header is on the include path.
`include "sdc_consts.svh"

package sdc_pkg;

    // Loop phases after a loop reset.
    typedef enum logic [2:0] {
        ST_RESET   = 3'b001,
        ST_MEASURE = 3'b010,
        ST_TRACK   = 3'b100
    } dll_state_t;

    // Offset unit operating modes.
    typedef enum logic [1:0] {
        OFS_STATIC   = 2'h0,
        OFS_DYN_ADD  = 2'h1,
        OFS_DYN_SUB  = 2'h2,
        OFS_DYN_BOTH = 2'h3
    } offset_mode_t;

    typedef struct packed {
        dll_state_t  state;
        logic        ref_s1;
        logic        ref_s2;
        logic        ref_prev;
        logic [7:0]  per_cnt;
        logic [7:0]  period;
        logic [5:0]  setting;
        logic        upndn;
        logic [8:0]  lock_cnt;
        logic        locked;
        logic [2:0]  upd_cnt;
        logic        upd_en;
    } dll_regs_t;

    typedef struct packed {
        logic        pin_s1;
        logic        pin_s2;
        logic [31:0] hist;
        logic [5:0]  set_lat;
        logic [6:0]  sum_lat;
        logic        strobe;
    } lane_regs_t;

    // Largest combined setting of a frequency mode.
    function automatic logic [6:0] max_setting(input logic [1:0] mode);
        max_setting = (mode == 2'h0) ? `SDC_MAX_M0 : `SDC_MAX_M123;
    endfunction : max_setting

    // Largest value the loop counter or a user setting may hold.
    function automatic logic [5:0] cnt_max(input logic [1:0] mode);
        cnt_max = (mode == 2'h0) ? `SDC_CNT_M0 : `SDC_CNT_M123;
    endfunction : cnt_max

endpackage : sdc_pkg

// *** core/sdc_strobe_lane.sv ***
// One strobe logic block: setting latches, delay chain, postamble gate.
// Assumes the pin is asynchronous and the update enable is on clk_in.
`timescale 1ns/1ns
`include "sdc_consts.svh"

module sdc_strobe_lane (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       pin_in,
    input  wire logic       postamble_in,
    input  wire logic       upd_en_in,
    input  wire logic [5:0] setting_in,
    input  wire logic [6:0] sum_in,
    input  wire logic       use_offset_in,
    input  wire logic [1:0] extra_elems_in,
    input  wire logic       bypass_in,
    output logic            strobe_out
);

    sdc_pkg::lane_regs_t r_ff;
    sdc_pkg::lane_regs_t nxt_r;
    logic [8:0]          taps;

    // ========================================================
    // Chain length and next state
    // ========================================================
    // The pin-side element uses the setting or the setting plus offset;
    // the further elements use the plain setting only.
    always_comb begin
        taps = (use_offset_in ? {2'h0, r_ff.sum_lat}
                              : {3'h0, r_ff.set_lat})
             + 9'(extra_elems_in) * {3'h0, r_ff.set_lat};
        nxt_r = r_ff;
        nxt_r.pin_s1 = pin_in;
        nxt_r.pin_s2 = r_ff.pin_s1;
        nxt_r.hist = {r_ff.hist[30:0], r_ff.pin_s2};
        if (upd_en_in) begin
            nxt_r.set_lat = setting_in;
            nxt_r.sum_lat = sum_in;
        end
        if (postamble_in) begin
            nxt_r.strobe = 1'b0;
        end else if (bypass_in) begin
            nxt_r.strobe = r_ff.pin_s2;
        end else begin
            nxt_r.strobe = r_ff.hist[taps[8:4]];
        end
    end

    // Register the lane state.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            r_ff <= '{pin_s1: 1'b0, pin_s2: 1'b0,
                      hist: `SDC_HIST_RST,
                      set_lat: `SDC_SETTING_RST, sum_lat: 7'h00,
                      strobe: 1'b0};
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign strobe_out = r_ff.strobe;

endmodule : sdc_strobe_lane

// *** verif/sdc_chk.sv ***
// Port checker for the strobe delay control block, bound to its top.
// Assumes a reference period of ten system clock cycles in the bench.
`timescale 1ns/1ns

module sdc_chk (
    input wire logic       clk_in,
    input wire logic       rst_in,
    input wire logic       dll_reset_in,
    input wire logic [1:0] freq_mode_in,
    input wire logic       zero_shift_in,
    input wire logic       dqs_pin_in,
    input wire logic       dqs_postamble_in,
    input wire logic       dqsn_postamble_in,
    input wire logic [5:0] delay_setting_out,
    input wire logic       upndn_out,
    input wire logic       upd_en_out,
    input wire logic       locked_out,
    input wire logic       dqs_shifted_out,
    input wire logic       dqsn_shifted_out
);
    localparam int LOCK_MIN = 2500;
    logic [2:0]  rst_age_ff;
    logic [11:0] dll_age_ff;

    // ========================================================
    // Helper ages and properties
    // Ages since reset and since loop reset, both saturating.
    always_ff @(posedge clk_in) begin
        rst_age_ff <= rst_in ? 3'h0 : rst_age_ff + {2'h0, rst_age_ff != 3'h7};
        dll_age_ff <= (rst_in || dll_reset_in) ? 12'h000
                    : dll_age_ff + {11'h000, dll_age_ff != 12'hFFF};
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sequence quiet_upd;
        !upd_en_out [*8];
    endsequence

    reset_clear_a: assert property (disable iff (1'b0) rst_in |=>
        {delay_setting_out, upndn_out, upd_en_out, locked_out,
         dqs_shifted_out, dqsn_shifted_out} == 11'h000)
        else $error("outputs not cleared by reset");
    loop_reset_a: assert property (dll_reset_in |=>
        delay_setting_out == 6'h00 && !locked_out)
        else $error("loop reset left setting or lock");
    step_dir_a: assert property (!dll_reset_in && !$past(dll_reset_in)
        && $changed(delay_setting_out) |->
        (upndn_out && delay_setting_out == $past(delay_setting_out) + 6'h01)
        || (!upndn_out && delay_setting_out == $past(delay_setting_out) - 6'h01))
        else $error("setting step wrong in size or direction");
    five_bit_a: assert property (freq_mode_in != 2'h0
        && $stable(freq_mode_in) && delay_setting_out <= 6'h1F
        |=> delay_setting_out <= 6'h1F)
        else $error("setting left five-bit range");
    zero_freeze_a: assert property (zero_shift_in && $past(zero_shift_in)
        && !$past(dll_reset_in) |-> $stable(delay_setting_out))
        else $error("setting moved during zero shift");
    upd_pulse_a: assert property (upd_en_out |=> quiet_upd)
        else $error("update enable too long or too frequent");
    dqs_gate_a: assert property (dqs_postamble_in |=> !dqs_shifted_out)
        else $error("postamble did not gate strobe");
    dqsn_gate_a: assert property (dqsn_postamble_in |=> !dqsn_shifted_out)
        else $error("postamble did not gate inverse strobe");
    bypass_lat_a: assert property (rst_age_ff == 3'h7 && zero_shift_in
        && $past(zero_shift_in) && $past(zero_shift_in, 2)
        && !$past(dqs_postamble_in) |-> dqs_shifted_out == $past(dqs_pin_in, 3))
        else $error("bypass path latency wrong");
    lock_early_a: assert property ($rose(locked_out)
        |-> dll_age_ff >= LOCK_MIN)
        else $error("lock came too early");
    lock_late_a: assert property (dll_age_ff == 12'hC80 |-> locked_out)
        else $error("lock missing");
endmodule : sdc_chk

bind strobe_delay_dll_control sdc_chk sdc_chk_inst (
    .clk_in, .rst_in, .dll_reset_in, .freq_mode_in, .zero_shift_in,
    .dqs_pin_in, .dqs_postamble_in, .dqsn_postamble_in, .delay_setting_out,
    .upndn_out, .upd_en_out, .locked_out, .dqs_shifted_out, .dqsn_shifted_out);

// *** verif/sdc_mem_model.sv ***
// Memory-side strobe driver for the strobe delay control bench.
// Assumes go_in is high for one system clock cycle per read burst.
`timescale 1ns/1ns

module sdc_mem_model (
    input  wire logic clk_in,
    input  wire logic go_in,
    output logic      dqs_out,
    output logic      dqsn_out
);
    int   left = 0;
    logic hi;
    logic last = 1'b0;

    // ========================================================
    // Burst driver
    // Idle level before the first burst.
    initial begin
        dqs_out = 1'b1;
        dqsn_out = 1'b0;
    end

    // Preamble, four strobe periods, postamble, then the pins are released.
    always @(negedge clk_in) begin
        if (left == 0 && go_in === 1'b1)
            left = 40;
        hi = left <= 36 && left >= 5 && ((36 - left) / 4) % 2 == 0;
        if (left != 0) begin
            last = hi;
            dqs_out = hi;
            dqsn_out = ~hi;
            left--;
        end else begin
            dqs_out = ~last; // Released pin shows the inverse level.
            dqsn_out = last;
        end
    end
endmodule : sdc_mem_model

// *** verif/tb.sv ***
// Self-checking bench for the strobe delay control block.
// Assumes the bound checker and the memory model in the verif folder.
`timescale 1ns/1ns
`include "sdc_consts.svh"

module tb;
    logic       clk_in, rst_in, ref_clk_in, dll_reset_in, zero_shift_in;
    logic       addnsub_in, user_sel_in, use_offset_in, go, meas_on;
    logic       dqs_postamble_in, dqsn_postamble_in, dqs_pin_in, dqsn_pin_in;
    logic [1:0] freq_mode_in, offset_mode_in, extra_elems_in;
    logic [6:0] static_offset_in;
    logic [5:0] dyn_offset_in, user_delay_in, delay_setting_out;
    logic       upndn_out, upd_en_out, locked_out, pin_prev, out_prev;
    logic       dqs_shifted_out, dqsn_shifted_out;
    int         n_mismatch = 0;
    int         samples_checked = 0;
    int         cyc = 0;
    int         n_rise = 0;
    int         exp_lat, lo;
    int         rise_q[$];
    int         elems[4] = '{`SDC_ELEMS_M0, `SDC_ELEMS_M1,
                             `SDC_ELEMS_M2, `SDC_ELEMS_M3};
    logic [5:0] ud[4] = '{6'h20, 6'h10, 6'h0C, 6'h3F};
    int         ue[4] = '{0, 3, 2, 0};
    // Chain latency seen here is four cycles plus taps/16; bypass is three.
    int         ul[4] = '{6, 8, 6, 7};

    strobe_delay_dll_control strobe_delay_dll_control_inst (
        .clk_in, .rst_in, .ref_clk_in, .dll_reset_in, .freq_mode_in,
        .zero_shift_in, .offset_mode_in, .static_offset_in, .dyn_offset_in,
        .addnsub_in, .user_sel_in, .user_delay_in, .use_offset_in,
        .extra_elems_in, .dqs_pin_in, .dqsn_pin_in, .dqs_postamble_in,
        .dqsn_postamble_in, .delay_setting_out, .upndn_out, .upd_en_out,
        .locked_out, .dqs_shifted_out, .dqsn_shifted_out);
    sdc_mem_model sdc_mem_model_inst (.clk_in, .go_in(go),
        .dqs_out(dqs_pin_in), .dqsn_out(dqsn_pin_in));

    // ========================================================
    // Clocks, watchdog and shared tasks
    // System clock of 8 ns.
    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end
    // Reference clock of 80 ns, phase unrelated to the system clock.
    initial begin
        ref_clk_in = 1'b0;
        #3;
        forever #40 ref_clk_in = ~ref_clk_in;
    end
    // Cuts a hang short well after the expected run length.
    initial begin
        #400000;
        n_mismatch++;
        test_done();
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : check

    task automatic wait_upd(input int n);
        int k;
        k = 0;
        while (n > 0 && k < 400) begin
            @(posedge clk_in);
            k++;
            if (upd_en_out === 1'b1)
                n--;
        end
        check(n, 0);
        @(negedge clk_in);
    endtask : wait_upd

    task automatic burst();
        @(posedge clk_in);
        go = 1'b1;
        @(posedge clk_in);
        go = 1'b0;
        repeat (42) @(negedge clk_in);
    endtask : burst

    task automatic measure(input int lat);
        wait_upd(2);
        rise_q.delete();
        exp_lat = lat;
        meas_on = 1'b1;
        burst();
        repeat (12) @(negedge clk_in);
        meas_on = 1'b0;
        check(rise_q.size(), 0);
    endtask : measure

    task automatic relock(input logic [1:0] m);
        int k;
        k = 0;
        dll_reset_in = 1'b1;
        freq_mode_in = m;
        repeat (4) @(negedge clk_in);
        dll_reset_in = 1'b0;
        while (locked_out !== 1'b1 && k < 4000) begin
            @(negedge clk_in);
            k++;
        end
        check(k >= 2550 && k < 3200, 1);
    endtask : relock

    // Pairs each pin rise during a measurement with its delayed output rise.
    always @(posedge clk_in) begin
        cyc++;
        if (meas_on && dqs_pin_in === 1'b1 && pin_prev === 1'b0)
            rise_q.push_back(cyc);
        if (dqs_shifted_out === 1'b1 && out_prev === 1'b0) begin
            n_rise++;
            if (meas_on)
                check(rise_q.size() > 0 ? cyc - rise_q.pop_front() : 99,
                      exp_lat);
        end
        pin_prev = dqs_pin_in;
        out_prev = dqs_shifted_out;
    end

    // Main sequence: lock per mode, offsets, user settings, bypass, gate.
    initial begin
        {rst_in, dll_reset_in, zero_shift_in, addnsub_in, go} = 5'h10;
        {user_sel_in, dqs_postamble_in, dqsn_postamble_in, meas_on} = 4'h0;
        {freq_mode_in, offset_mode_in, extra_elems_in} = 6'h00;
        {use_offset_in, static_offset_in} = 8'h80;
        {dyn_offset_in, user_delay_in} = 12'h000;
        {pin_prev, out_prev} = 2'h0;
        repeat (2) @(negedge clk_in);
        rst_in = 1'b0;
        check({delay_setting_out, upndn_out, upd_en_out, locked_out,
               dqs_shifted_out, dqsn_shifted_out}, 0);
        for (int i = 0; i < 4; i++) begin
            relock(2'((i + 1) % 4));
            repeat (50) @(negedge clk_in);
            lo = (10 * `SDC_TAPS_PER_CLK - 1) / elems[freq_mode_in];
            check(delay_setting_out === lo[5:0]
                  || delay_setting_out === lo[5:0] + 6'h01, 1);
            if (freq_mode_in == 2'h1) begin
                static_offset_in = 7'h1F;
                measure(6);
                static_offset_in = 7'h60;
                measure(4);
            end
        end
        dyn_offset_in = 6'h3F;
        for (int k = 0; k < 6; k++) begin
            offset_mode_in = k < 2 ? 2'h0 : (k < 4 ? 2'(k - 1) : 2'h3);
            static_offset_in = k[0] ? 7'h40 : 7'h3F;
            addnsub_in = ~k[0];
            measure(k[0] ? 4 : 8);
        end
        use_offset_in = 1'b0;
        user_sel_in = 1'b1;
        for (int k = 0; k < 4; k++) begin
            user_delay_in = ud[k];
            extra_elems_in = ue[k][1:0];
            measure(ul[k]);
        end
        zero_shift_in = 1'b1;
        measure(3);
        dqs_postamble_in = 1'b1;
        dqsn_postamble_in = 1'b1;
        lo = n_rise;
        burst();
        check(n_rise - lo, 0);
        test_done();
    end
endmodule : tb
